/* File: asg_clkgen_txdata.v */
/*
 Sample-rate generator and transmit holding words of an audio serializer.
 Assumes a 16-bit processor port, a 32-bit DMA port and synchronous pins.
*/
`timescale 1ns/1ns
`include "asg_consts.vh"

// Behaviour
// - Master bit clock is sysclk over 2..256.
// - Master frame sync is bitclk over 8..256.
// - Slave mode ignores both divider fields.
// - Two 32-bit transmit words, left and right.
// - CPU sees 16-bit halves; DMA whole words.
// - Left low half holds bits 15:0.
// - Left high half holds bits 31:16.
// - Right low half holds bits 15:0.
// - Right high half holds bits 31:16.
// - Master drives pins; slave passes inputs undivided.
module asg_clkgen_txdata #(
	parameter DW = 16
) (
	input  wire          core_clk_i,
	input  wire          rst_i,
	input  wire          ce_i,
	input  wire          master_mode_i,
	input  wire          cpu_wr_i,
	input  wire          cpu_rd_i,
	input  wire [2:0]    cpu_idx_i,
	input  wire [DW-1:0] cpu_wdata_i,
	output reg  [DW-1:0] cpu_rdata_o,
	input  wire          dma_wr_i,
	input  wire          dma_right_i,
	input  wire [31:0]   dma_wdata_i,
	input  wire          serial_bit_clock_pin_i,
	input  wire          frame_sync_pin_i,
	output reg           serial_bit_clock_pin_o,
	output reg           serial_bit_clock_pin_oe_o,
	output reg           frame_sync_pin_o,
	output reg           frame_sync_pin_oe_o,
	output reg  [31:0]   tx_left_word_o,
	output reg  [31:0]   tx_right_word_o
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [5:0]    srate_r;
	reg  [15:0]   txl_lo_r;
	reg  [15:0]   txl_hi_r;
	reg  [15:0]   txr_lo_r;
	reg  [15:0]   txr_hi_r;
	localparam    DIV_CW = 8;
	wire [2:0]    bcr_w = srate_r[`ASG_BCR_MSB:`ASG_BCR_LSB];
	wire [2:0]    fsr_w = srate_r[`ASG_FSR_MSB:`ASG_FSR_LSB];

	// Decode one write enable per half; used for CPU write path
	function hit;
		input       wr;
		input [2:0] idx;
		input [2:0] want;
		begin
			hit = wr && (idx == want);
		end
	endfunction

	// Divider exponent; codes above the top clamp to the top ratio
	function [3:0] ratio_log;
		input [2:0] code;
		input [2:0] top;
		input [3:0] base;
		begin
			if (code > top)
				ratio_log = {1'b0, top} + base;
			else
				ratio_log = {1'b0, code} + base;
		end
	endfunction

	// ----------------------------------------
	// Write strobes
	// ----------------------------------------
	// DMA word write wins over a CPU half write in the same cycle
	wire          dma_l_w = dma_wr_i & ~dma_right_i;
	wire          dma_r_w = dma_wr_i & dma_right_i;
	wire          wr_sr_w = hit(cpu_wr_i, cpu_idx_i, `ASG_IDX_SRATE);
	wire          wr_ll_w = hit(cpu_wr_i, cpu_idx_i, `ASG_IDX_TXL_LO) & ~dma_l_w;
	wire          wr_lh_w = hit(cpu_wr_i, cpu_idx_i, `ASG_IDX_TXL_HI) & ~dma_l_w;
	wire          wr_rl_w = hit(cpu_wr_i, cpu_idx_i, `ASG_IDX_TXR_LO) & ~dma_r_w;
	wire          wr_rh_w = hit(cpu_wr_i, cpu_idx_i, `ASG_IDX_TXR_HI) & ~dma_r_w;

	// ----------------------------------------
	// Divider fields and holding words
	// ----------------------------------------
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			srate_r <= `ASG_SRATE_RST;
		end else if (ce_i) begin
			if (wr_sr_w)
				srate_r <= cpu_wdata_i[`ASG_FSR_MSB:`ASG_BCR_LSB];
		end
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			txl_lo_r <= `ASG_HALF_RST;
			txl_hi_r <= `ASG_HALF_RST;
		end else if (ce_i) begin
			if (dma_l_w) begin
				txl_lo_r <= dma_wdata_i[`ASG_LO_MSB:`ASG_LO_LSB];
				txl_hi_r <= dma_wdata_i[`ASG_HI_MSB:`ASG_HI_LSB];
			end
			if (wr_ll_w)
				txl_lo_r <= cpu_wdata_i[`ASG_LO_MSB:`ASG_LO_LSB];
			if (wr_lh_w)
				txl_hi_r <= cpu_wdata_i[`ASG_LO_MSB:`ASG_LO_LSB];
		end
	end

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			txr_lo_r <= `ASG_HALF_RST;
			txr_hi_r <= `ASG_HALF_RST;
		end else if (ce_i) begin
			if (dma_r_w) begin
				txr_lo_r <= dma_wdata_i[`ASG_LO_MSB:`ASG_LO_LSB];
				txr_hi_r <= dma_wdata_i[`ASG_HI_MSB:`ASG_HI_LSB];
			end
			if (wr_rl_w)
				txr_lo_r <= cpu_wdata_i[`ASG_LO_MSB:`ASG_LO_LSB];
			if (wr_rh_w)
				txr_hi_r <= cpu_wdata_i[`ASG_LO_MSB:`ASG_LO_LSB];
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	reg [15:0] rd_nxt;
	always @* begin
		// Unmapped indices read as zero
		rd_nxt = 16'h0000;
		if (cpu_idx_i == `ASG_IDX_SRATE)
			rd_nxt = {10'h000, srate_r} & `ASG_SRATE_MASK;
		else if (cpu_idx_i == `ASG_IDX_TXL_LO)
			rd_nxt = txl_lo_r;
		else if (cpu_idx_i == `ASG_IDX_TXL_HI)
			rd_nxt = txl_hi_r;
		else if (cpu_idx_i == `ASG_IDX_TXR_LO)
			rd_nxt = txr_lo_r;
		else if (cpu_idx_i == `ASG_IDX_TXR_HI)
			rd_nxt = txr_hi_r;
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			cpu_rdata_o     <= {DW{1'b0}};
			tx_left_word_o  <= {`ASG_HALF_RST, `ASG_HALF_RST};
			tx_right_word_o <= {`ASG_HALF_RST, `ASG_HALF_RST};
		end else if (ce_i) begin
			if (cpu_rd_i)
				cpu_rdata_o <= rd_nxt[DW-1:0];
			tx_left_word_o  <= {txl_hi_r, txl_lo_r};
			tx_right_word_o <= {txr_hi_r, txr_lo_r};
		end
	end

	// ----------------------------------------
	// Clock generators
	// ----------------------------------------
	// Reserved frame ratios clamp to 256 so the pin never stalls
	wire [3:0] bcr_log = ratio_log(bcr_w, `ASG_BCR_MAX, `ASG_BCR_BASE);
	wire [3:0] fsr_log = ratio_log(fsr_w, `ASG_FSR_MAX, `ASG_FSR_BASE);
	// Slave mode parks both dividers, but a frozen enable leaves them be
	wire       gen_rst = rst_i | (ce_i & ~master_mode_i);
	wire       bclk_w;
	wire       bclk_fall_w;
	wire       fs_w;

	asg_divider #(.CW(DIV_CW)) u_bclk_div (
		.core_clk_i (core_clk_i),
		.rst_i      (gen_rst),
		.tick_i     (ce_i),
		.log2_i     (bcr_log),
		.clk_o      (bclk_w),
		.rise_o     (),
		.fall_o     (bclk_fall_w)
	);

	// Frame sync advances on bit clock falling edges only
	asg_divider #(.CW(DIV_CW)) u_fs_div (
		.core_clk_i (core_clk_i),
		.rst_i      (gen_rst),
		.tick_i     (ce_i & bclk_fall_w),
		.log2_i     (fsr_log),
		.clk_o      (fs_w),
		.rise_o     (),
		.fall_o     ()
	);

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	// Slave inputs are registered once onto the pin outputs; synchronizer lies downstream
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			serial_bit_clock_pin_o    <= 1'b0;
			serial_bit_clock_pin_oe_o <= 1'b0;
		end else if (ce_i) begin
			serial_bit_clock_pin_oe_o <= master_mode_i;
			serial_bit_clock_pin_o    <= master_mode_i ? bclk_w : serial_bit_clock_pin_i;
		end
	end

	// Frame sync pin turns round together with the bit clock pin
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			frame_sync_pin_o    <= 1'b0;
			frame_sync_pin_oe_o <= 1'b0;
		end else if (ce_i) begin
			frame_sync_pin_oe_o <= master_mode_i;
			frame_sync_pin_o    <= master_mode_i ? fs_w : frame_sync_pin_i;
		end
	end
endmodule // asg_clkgen_txdata

/* File: asg_clkgen_txdata_sva.sv */
/* Checker for the serializer clock generator and holding words.
 Assumes binding by name to the top module, one clock domain. */
`timescale 1ns/1ns
module asg_chk #(parameter DW = 16) (
	input logic core_clk_i,
	input logic rst_i,
	input logic ce_i,
	input logic master_mode_i,
	input logic cpu_wr_i,
	input logic cpu_rd_i,
	input logic [2:0] cpu_idx_i,
	input logic [DW-1:0] cpu_wdata_i,
	input logic [DW-1:0] cpu_rdata_o,
	input logic dma_wr_i,
	input logic dma_right_i,
	input logic [31:0] dma_wdata_i,
	input logic serial_bit_clock_pin_i,
	input logic frame_sync_pin_i,
	input logic serial_bit_clock_pin_o,
	input logic serial_bit_clock_pin_oe_o,
	input logic frame_sync_pin_o,
	input logic frame_sync_pin_oe_o,
	input logic [31:0] tx_left_word_o,
	input logic [31:0] tx_right_word_o
);
logic [31:0] sh_l, sh_r;
default clocking @(posedge core_clk_i); endclocking
default disable iff (rst_i);
// ----
// Shadow words; DMA wins a same-cycle clash
// ----
always @(posedge core_clk_i)
	if (rst_i) {sh_l, sh_r} <= 64'h0;
	else if (ce_i) begin
		if (dma_wr_i & !dma_right_i) sh_l <= dma_wdata_i;
		else if (cpu_wr_i & cpu_idx_i == 3'h1) sh_l[15:0] <= cpu_wdata_i;
		else if (cpu_wr_i & cpu_idx_i == 3'h2) sh_l[31:16] <= cpu_wdata_i;
		if (dma_wr_i & dma_right_i) sh_r <= dma_wdata_i;
		else if (cpu_wr_i & cpu_idx_i == 3'h3) sh_r[15:0] <= cpu_wdata_i;
		else if (cpu_wr_i & cpu_idx_i == 3'h4) sh_r[31:16] <= cpu_wdata_i;
	end
sequence s_rd(i); cpu_rd_i && ce_i && cpu_idx_i == i; endsequence
sequence s_mst; master_mode_i && ce_i; endsequence
// Words follow the holding halves one enabled edge later
property p_txl; ce_i |=> tx_left_word_o == $past(sh_l); endproperty
a_txl: assert property (p_txl) else $error("left word off");
property p_txr; ce_i |=> tx_right_word_o == $past(sh_r); endproperty
a_txr: assert property (p_txr) else $error("right word off");
property p_oe; ce_i |=> serial_bit_clock_pin_oe_o == $past(master_mode_i)
	&& frame_sync_pin_oe_o == $past(master_mode_i); endproperty
a_oe: assert property (p_oe) else $error("pin enable off");
property p_sclk; !master_mode_i && ce_i |=> serial_bit_clock_pin_o == $past(serial_bit_clock_pin_i); endproperty
a_sclk: assert property (p_sclk) else $error("slave clock off");
property p_sfs; !master_mode_i && ce_i |=> frame_sync_pin_o == $past(frame_sync_pin_i); endproperty
a_sfs: assert property (p_sfs) else $error("slave sync off");
property p_rdl; s_rd(3'h1) |=> cpu_rdata_o == $past(sh_l[15:0]); endproperty
a_rdl: assert property (p_rdl) else $error("left read off");
property p_rsv; s_rd(3'h0) |=> cpu_rdata_o[15:6] == 10'h0; endproperty
a_rsv: assert property (p_rsv) else $error("reserved bits set");
property p_bclk; s_mst |-> ##[1:300] ($changed(serial_bit_clock_pin_o) || !master_mode_i || !ce_i);
endproperty
a_bclk: assert property (p_bclk) else $error("bit clock stuck");
endmodule // asg_chk
bind asg_clkgen_txdata asg_chk #(.DW(DW)) u_chk (.core_clk_i, .rst_i, .ce_i, .master_mode_i,
	.cpu_wr_i, .cpu_rd_i, .cpu_idx_i, .cpu_wdata_i, .cpu_rdata_o, .dma_wr_i, .dma_right_i,
	.dma_wdata_i, .serial_bit_clock_pin_i, .frame_sync_pin_i, .serial_bit_clock_pin_o,
	.serial_bit_clock_pin_oe_o, .frame_sync_pin_o, .frame_sync_pin_oe_o, .tx_left_word_o,
	.tx_right_word_o);

/* File: asg_clkgen_txdata_tb_top.sv */
/* Bench: register tasks, divider ratios and slave pass-through.
 Assumes the codec model and the bound checker. */
`timescale 1ns/1ns
`define CHK(s, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %h got %h", s, e, a); end end
module asg_clkgen_txdata_tb_top;
logic core_clk_i = 0, rst_i = 1, ce_i = 1, master_mode_i = 0;
logic cpu_wr_i = 0, cpu_rd_i = 0, dma_wr_i = 0, dma_right_i = 0;
logic [2:0] cpu_idx_i = 0;
logic [15:0] cpu_wdata_i = 0, cpu_rdata_o;
logic [31:0] dma_wdata_i = 0, tx_left_word_o, tx_right_word_o;
logic serial_bit_clock_pin_o, serial_bit_clock_pin_oe_o, frame_sync_pin_o, frame_sync_pin_oe_o;
logic cbc, cfs;
int err_count = 0, checked = 0, cyc = 0, n;
wire bc_w = serial_bit_clock_pin_oe_o ? serial_bit_clock_pin_o : cbc;
wire fs_w = frame_sync_pin_oe_o ? frame_sync_pin_o : cfs;
always #10 core_clk_i = !core_clk_i;
asg_codec cod (.clk_i(core_clk_i), .en_i(!master_mode_i && !rst_i), .bclk_o(cbc), .fs_o(cfs));
asg_clkgen_txdata dut (.core_clk_i, .rst_i, .ce_i, .master_mode_i, .cpu_wr_i, .cpu_rd_i,
	.cpu_idx_i, .cpu_wdata_i, .cpu_rdata_o, .dma_wr_i, .dma_right_i, .dma_wdata_i,
	.serial_bit_clock_pin_i(bc_w), .frame_sync_pin_i(fs_w), .serial_bit_clock_pin_o,
	.serial_bit_clock_pin_oe_o, .frame_sync_pin_o, .frame_sync_pin_oe_o,
	.tx_left_word_o, .tx_right_word_o);
task conclude;
	if (err_count == 0 && checked > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask
task wr(input logic [2:0] i, input logic [15:0] d);
	@(posedge core_clk_i) #2 {cpu_wr_i, cpu_idx_i, cpu_wdata_i} = {1'b1, i, d};
	@(posedge core_clk_i) #2 cpu_wr_i = 0;
endtask
task rd(input logic [2:0] i, input logic [15:0] e);
	@(posedge core_clk_i) #2 {cpu_rd_i, cpu_idx_i} = {1'b1, i};
	@(posedge core_clk_i) #2 cpu_rd_i = 0;
	`CHK("rdata", e, cpu_rdata_o)
endtask
task dma(input logic r, input logic [31:0] d);
	@(posedge core_clk_i) #2 {dma_wr_i, dma_right_i, dma_wdata_i} = {1'b1, r, d};
	@(posedge core_clk_i) #2 dma_wr_i = 0;
endtask
// Cycles between two rising edges of the chosen output pin
task per(input logic s, output int m);
	int r;
	logic p, c;
	r = 0;
	m = 0;
	p = 1;
	while (r < 2) begin
		@(posedge core_clk_i) #2 c = s ? frame_sync_pin_o : serial_bit_clock_pin_o;
		m += int'(r == 1);
		r += int'(c === 1'b1 && p === 1'b0);
		p = c;
	end
endtask
always @(posedge core_clk_i) if (++cyc == 20000) begin err_count++; conclude; end
initial begin
	repeat (8) @(posedge core_clk_i);
	#2 rst_i = 0;
	for (int i = 0; i < 5; i++) rd(3'(i), 16'h0);
	wr(1, 16'h1111);
	wr(2, 16'h2222);
	wr(3, 16'h3333);
	wr(4, 16'h4444);
	wr(1, 16'hffff);
	wr(5, 16'hdead);
	rd(1, 16'hffff);
	rd(2, 16'h2222);
	rd(3, 16'h3333);
	rd(4, 16'h4444);
	rd(5, 16'h0);
	`CHK("left", 32'h2222ffff, tx_left_word_o)
	`CHK("right", 32'h44443333, tx_right_word_o)
	dma(0, 32'h89abcdef);
	dma(1, 32'h01234567);
	rd(1, 16'hcdef);
	rd(2, 16'h89ab);
	rd(4, 16'h0123);
	wr(4, 16'h5555);
	rd(3, 16'h4567);
	ce_i = 0;
	wr(3, 16'h0);
	ce_i = 1;
	rd(3, 16'h4567);
	wr(0, 16'hffff);
	rd(0, 16'h003f);
	master_mode_i = 1;
	for (int k = 0; k < 8; k++) begin
		wr(0, 16'(k));
		per(0, n);
		per(0, n);
		`CHK("bclk", 2 << k, n)
	end
	`CHK("bclk oe", 1'b1, serial_bit_clock_pin_oe_o)
	`CHK("fs oe", 1'b1, frame_sync_pin_oe_o)
	for (int j = 0; j < 6; j++) begin
		wr(0, 16'(j << 3));
		per(1, n);
		per(1, n);
		`CHK("fs", 16 << j, n)
	end
	wr(0, 16'h0038);
	per(1, n);
	per(1, n);
	`CHK("fs reserved", 512, n)
	master_mode_i = 0;
	wr(0, 16'h0007);
	per(1, n);
	per(1, n);
	`CHK("slave fs", 48, n)
	`CHK("oe", 1'b0, serial_bit_clock_pin_oe_o)
	`CHK("slave fs oe", 1'b0, frame_sync_pin_oe_o)
	conclude;
end
endmodule // asg_clkgen_txdata_tb_top

/* File: asg_codec.sv */
/* Codec model giving bit clock and frame sync to a slave device.
 Assumes enable is high only while the device is slave. */
`timescale 1ns/1ns
module asg_codec #(parameter HALF = 3) (
	input logic clk_i,
	input logic en_i,
	output logic bclk_o,
	output logic fs_o
);
int n, b;
// Clocks stand still low while released
always @(posedge clk_i)
	if (!en_i) {n, b, bclk_o, fs_o} <= '0;
	else if (n == HALF - 1) begin
		n <= 0;
		bclk_o <= !bclk_o;
		b <= b + int'(bclk_o);
		if (bclk_o && b % 4 == 3) fs_o <= !fs_o;
	end else n <= n + 1;
endmodule // asg_codec

/* File: asg_consts.vh */
/*
 Constants for the audio serial clock generator and transmit holding words.
 Assumes inclusion by bare name from design files in the same folder.
*/
`ifndef ASG_CONSTS_VH
`define ASG_CONSTS_VH

// ----------------------------------------
// Register indices (no offsets are printed)
// ----------------------------------------
`define ASG_IDX_SRATE     3'h0
`define ASG_IDX_TXL_LO    3'h1
`define ASG_IDX_TXL_HI    3'h2
`define ASG_IDX_TXR_LO    3'h3
`define ASG_IDX_TXR_HI    3'h4

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define ASG_BCR_LSB       0
`define ASG_BCR_MSB       2
`define ASG_FSR_LSB       3
`define ASG_FSR_MSB       5
`define ASG_SRATE_MASK    16'h003f
`define ASG_SRATE_RST     6'h00
`define ASG_HALF_RST      16'h0000
`define ASG_FSR_MAX       3'h5
`define ASG_BCR_BASE      4'h1
`define ASG_FSR_BASE      4'h3
`define ASG_BCR_MAX       3'h7
`define ASG_LO_LSB        0
`define ASG_LO_MSB        15
`define ASG_HI_LSB        16
`define ASG_HI_MSB        31

`endif

/* File: asg_divider.v */
/*
 Programmable power-of-two divider with 50% duty square output.
 Assumes an enable pulse per input tick; output toggles every ratio/2 ticks.
*/
`timescale 1ns/1ns
module asg_divider #(
	parameter CW = 8
) (
	input  wire          core_clk_i,
	input  wire          rst_i,
	input  wire          tick_i,
	input  wire [3:0]    log2_i,
	output reg           clk_o,
	output reg           rise_o,
	output reg           fall_o
);
	reg  [CW-1:0] cnt_r;
	wire [CW-1:0] half_w = {{(CW-1){1'b0}}, 1'b1} << (log2_i - 4'h1);

	always @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_r  <= {CW{1'b0}};
			clk_o  <= 1'b0;
			rise_o <= 1'b0;
			fall_o <= 1'b0;
		end else begin
			if (tick_i) begin
				if (cnt_r >= half_w - {{(CW-1){1'b0}}, 1'b1}) begin
					cnt_r  <= {CW{1'b0}};
					clk_o  <= ~clk_o;
					rise_o <= ~clk_o;
					fall_o <= clk_o;
				end else begin
					cnt_r  <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
					// Pulses last one enabled tick, so a frozen enable loses none
					rise_o <= 1'b0;
					fall_o <= 1'b0;
				end
			end
		end
	end
endmodule // asg_divider
